// File: common/sdram_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts of the SDRAM controller
// Assumes one 100 MHz clock that also clocks the external SDRAM
`ifndef SDRAM_CTRL_REGS_SVH
`define SDRAM_CTRL_REGS_SVH
`define REG_ENABLE_WIDTH 13'h1C02
`define REG_TIMING 13'h1C04
`define REG_POWER 13'h1C06
`define RST_ENABLE_WIDTH 16'h0002
`define RST_TIMING 16'h7AAF
`define RST_POWER 16'hC010
`define BIT_ENABLE 0
`define BIT_INIT_DONE 7
`define F_WIDTH 2:1
`define F_TRAS 15:12
`define F_TRFC 11:8
`define F_WRITE_RECOVERY_TIME 7:6
`define F_PRECHARGE_PERIOD 5:4
`define F_TRCD 3:2
`define F_CL 1:0
`define BIT_DYN_CKE 14
`define BIT_AUTO_PRE 3
`define F_SIZE 2:1
`define WIDTH_32 2'h2
`define CLK_PERIOD_NS 10
`define INIT_WAIT_NS 100000
`define REFRESH_PERIOD_NS 7800
`define REFRESH_CYCLES (`REFRESH_PERIOD_NS / `CLK_PERIOD_NS)
`define INIT_REFRESHES 2'h2
`define MRS_WAIT 5'h02
`define CMD_MRS 4'h0
`define CMD_REF 4'h1
`define CMD_PRE 4'h2
`define CMD_ACT 4'h3
`define CMD_WRITE 4'h4
`define CMD_READ 4'h5
`define CMD_NOP 4'h7
`endif

// File: common/sdram_ctrl_pkg.sv
// Types shared by the SDRAM controller modules
// Assumes sdram_ctrl_regs.svh for all numeric constants
package sdram_ctrl_pkg;
    typedef enum logic [9:0] {
        ST_OFF = 10'h001,
        ST_INIT_PRE = 10'h002,
        ST_INIT_REF = 10'h004,
        ST_INIT_MRS = 10'h008,
        ST_IDLE = 10'h010,
        ST_RW = 10'h020,
        ST_CAP = 10'h040,
        ST_CLOSE = 10'h080,
        ST_WAIT = 10'h100,
        ST_SPARE = 10'h200
    } state_t;
    typedef logic [3:0] cmd_t;
    typedef logic [4:0] cycles_t;
endpackage : sdram_ctrl_pkg

// File: common/sdram_timing_if.sv
// Decoded timing counts passed from the field decoder to the controller
// Assumes both ends run on the same clock
`timescale 1ns/10ps
interface sdram_timing_if;
    sdram_ctrl_pkg::cycles_t tras;
    sdram_ctrl_pkg::cycles_t trfc;
    sdram_ctrl_pkg::cycles_t write_recovery_time;
    sdram_ctrl_pkg::cycles_t precharge_period;
    sdram_ctrl_pkg::cycles_t trcd;
    sdram_ctrl_pkg::cycles_t cl;
    logic [3:0] col_bits;
    logic bus32;
    modport source (output tras, trfc, write_recovery_time, precharge_period, trcd, cl, col_bits, bus32);
    modport sink (input tras, trfc, write_recovery_time, precharge_period, trcd, cl, col_bits, bus32);
endinterface : sdram_timing_if

// File: rtl/sdram_timing_decode.sv
// Turns the configuration fields into clock counts and address layout
// Assumes register values are stable while the controller uses them
`timescale 1ns/10ps
`include "sdram_ctrl_regs.svh"
module sdram_timing_decode (
    input wire logic [15:0] timing,
    input wire logic [15:0] power,
    input wire logic [1:0] width,
    sdram_timing_if.source t
);
    // ****************************************
    // Field decode
    // ****************************************
    // Reserved codes fall back to the slowest setting
    assign t.tras = {1'b0, timing[`F_TRAS]} + 5'h01;
    assign t.trfc = (timing[`F_TRFC] < 4'h2) ? 5'h10 : {1'b0, timing[`F_TRFC]} + 5'h01;
    assign t.write_recovery_time = (timing[`F_WRITE_RECOVERY_TIME] == 2'h0) ? 5'h04 :
        {3'h0, timing[`F_WRITE_RECOVERY_TIME]} + 5'h01;
    assign t.precharge_period = (timing[`F_PRECHARGE_PERIOD] == 2'h0) ? 5'h04 :
        {3'h0, timing[`F_PRECHARGE_PERIOD]} + 5'h01;
    assign t.trcd = (timing[`F_TRCD] == 2'h2) ? 5'h02 : 5'h03;
    assign t.cl = (timing[`F_CL] == 2'h2) ? 5'h02 : 5'h03;
    assign t.bus32 = (width == `WIDTH_32);
    always_comb
    begin
        case ({t.bus32, power[`F_SIZE]})
            3'h0: t.col_bits = 4'h9;
            3'h1: t.col_bits = 4'h9;
            3'h2: t.col_bits = 4'hA;
            3'h3: t.col_bits = 4'h8;
            3'h4: t.col_bits = 4'h8;
            3'h5: t.col_bits = 4'h9;
            3'h6: t.col_bits = 4'h9;
            default: t.col_bits = 4'h8;
        endcase
    end
endmodule : sdram_timing_decode

// File: rtl/sdram_wait_timer.sv
// Down counter that spaces SDRAM commands
// Assumes load and value come from logic on the same clock
`timescale 1ns/10ps
module sdram_wait_timer (
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [14:0] value,
    output logic zero
);
    logic [14:0] count;
    always_ff @(posedge clk)
    begin
        if (reset)
            count <= 15'h0000;
        else if (load)
            count <= value;
        else if (count != 15'h0000)
            count <= count - 15'h0001;
    end
    assign zero = (count == 15'h0000);
endmodule : sdram_wait_timer

// File: rtl/sdram_ctrl.sv
// SDRAM configuration registers, initialization, refresh and single-word access
// Assumes the SDRAM is clocked by clk; one row kept open at a time
`timescale 1ns/10ps
`include "sdram_ctrl_regs.svh"
module sdram_ctrl #(
    parameter logic [14:0] INIT_WAIT_CYCLES = 15'(`INIT_WAIT_NS / `CLK_PERIOD_NS)
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [12:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic req,
    input wire logic req_we,
    input wire logic [23:0] req_addr,
    input wire logic [31:0] req_wdata,
    output logic req_ack,
    output logic [31:0] req_rdata,
    output logic mem_ready,
    output logic sdram_clock_enable_out,
    output logic sdram_cs_n,
    output logic sdram_ras_n,
    output logic sdram_cas_n,
    output logic sdram_we_n,
    output logic [1:0] sdram_ba,
    output logic [12:0] sdram_addr,
    output logic [31:0] sdram_dq_out,
    output logic [1:0] sdram_dq_oe,
    input wire logic [31:0] sdram_dq_in
);
    localparam logic [9:0] REFRESH_CYCLES = 10'(`REFRESH_CYCLES);

    // ****************************************
    // Declarations
    // ****************************************
    logic enable;
    logic [1:0] width;
    logic init_done;
    logic [15:0] timing;
    logic [15:0] power;
    sdram_ctrl_pkg::state_t state;
    sdram_ctrl_pkg::state_t ret_state;
    sdram_ctrl_pkg::state_t next_state;
    sdram_ctrl_pkg::state_t next_ret;
    sdram_ctrl_pkg::cmd_t cmd;
    sdram_ctrl_pkg::cmd_t next_cmd;
    logic [12:0] next_addr;
    logic [1:0] next_ba;
    logic load;
    logic [14:0] load_val;
    logic timer_zero;
    logic [1:0] ref_left;
    logic [9:0] refresh_count;
    logic refresh_due;
    logic row_open;
    logic [12:0] open_row;
    logic [1:0] open_bank;
    logic [4:0] ras_count;
    logic [4:0] wr_count;
    logic ras_ok;
    logic wr_ok;
    logic [31:0] dq_meta;
    logic [31:0] dq_sync;
    logic [23:0] col_mask;
    logic [12:0] req_col;
    logic [1:0] req_bank;
    logic [12:0] req_row;
    logic pending;
    logic work;
    logic auto_pre;
    logic dyn_cke;

    sdram_timing_if t ();

    sdram_timing_decode u_decode (
        .timing(timing),
        .power(power),
        .width(width),
        .t(t.source)
    );

    sdram_wait_timer u_timer (
        .clk(clk),
        .reset(reset),
        .load(load),
        .value(load_val),
        .zero(timer_zero)
    );

    // ****************************************
    // Register port
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            enable <= 1'b0;
            width <= 2'(`RST_ENABLE_WIDTH >> 1);
            timing <= `RST_TIMING;
            power <= `RST_POWER;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `REG_ENABLE_WIDTH:
                begin
                    enable <= reg_wdata[`BIT_ENABLE];
                    width <= reg_wdata[`F_WIDTH];
                end
                `REG_TIMING: timing <= reg_wdata;
                `REG_POWER: power <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `REG_ENABLE_WIDTH: reg_rdata <= {8'h00, init_done, 4'h0, width, enable};
                `REG_TIMING: reg_rdata <= timing;
                `REG_POWER: reg_rdata <= power;
                default: reg_rdata <= 16'h0000;
            endcase
        end
        else
            reg_rdata <= 16'h0000;
    end

    assign auto_pre = power[`BIT_AUTO_PRE];
    assign dyn_cke = power[`BIT_DYN_CKE];

    // ****************************************
    // Address split
    // ****************************************
    // Column width moves with size and bus width, so rows follow the column field
    assign col_mask = ~(24'hFFFFFF << t.col_bits);
    assign req_col = 13'(req_addr & col_mask);
    assign req_bank = 2'(req_addr >> t.col_bits);
    assign req_row = 13'(req_addr >> (t.col_bits + 4'h2));

    // Ack blocks its own cycle, while the master still holds req
    assign pending = req && !req_ack && enable && init_done;
    assign work = refresh_due || pending || !enable;
    assign ras_ok = ras_count >= t.tras - 5'h01;
    assign wr_ok = wr_count >= t.write_recovery_time - 5'h01;

    // ****************************************
    // Command sequencing
    // ****************************************
    always_comb
    begin
        next_state = state;
        next_ret = ret_state;
        next_cmd = `CMD_NOP;
        next_addr = sdram_addr;
        next_ba = sdram_ba;
        load = 1'b0;
        load_val = 15'h0000;
        case (state)
            sdram_ctrl_pkg::ST_OFF:
            begin
                if (enable && init_done)
                    next_state = sdram_ctrl_pkg::ST_IDLE;
                else if (enable)
                begin
                    next_state = sdram_ctrl_pkg::ST_WAIT;
                    next_ret = sdram_ctrl_pkg::ST_INIT_PRE;
                    load = 1'b1;
                    load_val = INIT_WAIT_CYCLES - 15'h0002;
                end
            end
            sdram_ctrl_pkg::ST_INIT_PRE:
            begin
                next_cmd = `CMD_PRE;
                next_addr = 13'h0400;
                next_state = sdram_ctrl_pkg::ST_WAIT;
                next_ret = sdram_ctrl_pkg::ST_INIT_REF;
                load = 1'b1;
                load_val = 15'(t.precharge_period) - 15'h0002;
            end
            sdram_ctrl_pkg::ST_INIT_REF:
            begin
                next_cmd = `CMD_REF;
                next_state = sdram_ctrl_pkg::ST_WAIT;
                next_ret = (ref_left == 2'h1) ? sdram_ctrl_pkg::ST_INIT_MRS : sdram_ctrl_pkg::ST_INIT_REF;
                load = 1'b1;
                load_val = 15'(t.trfc) - 15'h0002;
            end
            sdram_ctrl_pkg::ST_INIT_MRS:
            begin
                // Burst of one, sequential, latency from the field
                next_cmd = `CMD_MRS;
                next_addr = {6'h00, t.cl[2:0], 4'h0};
                next_ba = 2'h0;
                next_state = sdram_ctrl_pkg::ST_WAIT;
                next_ret = sdram_ctrl_pkg::ST_IDLE;
                load = 1'b1;
                load_val = 15'(`MRS_WAIT) - 15'h0002;
            end
            sdram_ctrl_pkg::ST_IDLE:
            begin
                if (!enable)
                    next_state = row_open ? sdram_ctrl_pkg::ST_CLOSE : sdram_ctrl_pkg::ST_OFF;
                else if (!sdram_clock_enable_out)
                    next_state = sdram_ctrl_pkg::ST_IDLE;
                else if (refresh_due)
                begin
                    if (row_open)
                        next_state = sdram_ctrl_pkg::ST_CLOSE;
                    else
                    begin
                        next_cmd = `CMD_REF;
                        next_state = sdram_ctrl_pkg::ST_WAIT;
                        next_ret = sdram_ctrl_pkg::ST_IDLE;
                        load = 1'b1;
                        load_val = 15'(t.trfc) - 15'h0002;
                    end
                end
                else if (pending)
                begin
                    if (row_open && open_row == req_row && open_bank == req_bank)
                        next_state = sdram_ctrl_pkg::ST_RW;
                    else if (row_open)
                        next_state = sdram_ctrl_pkg::ST_CLOSE;
                    else
                    begin
                        next_cmd = `CMD_ACT;
                        next_addr = req_row;
                        next_ba = req_bank;
                        next_state = sdram_ctrl_pkg::ST_WAIT;
                        next_ret = sdram_ctrl_pkg::ST_RW;
                        load = 1'b1;
                        load_val = 15'(t.trcd) - 15'h0002;
                    end
                end
            end
            sdram_ctrl_pkg::ST_RW:
            begin
                next_cmd = req_we ? `CMD_WRITE : `CMD_READ;
                next_addr = req_col | {2'h0, auto_pre, 10'h000};
                next_ba = req_bank;
                if (req_we)
                    next_state = auto_pre ? sdram_ctrl_pkg::ST_CLOSE : sdram_ctrl_pkg::ST_IDLE;
                else
                begin
                    // Two extra cycles cover the input synchroniser
                    next_state = sdram_ctrl_pkg::ST_WAIT;
                    next_ret = sdram_ctrl_pkg::ST_CAP;
                    load = 1'b1;
                    load_val = 15'(t.cl) + 15'h0001;
                end
            end
            sdram_ctrl_pkg::ST_CAP:
                next_state = auto_pre ? sdram_ctrl_pkg::ST_CLOSE : sdram_ctrl_pkg::ST_IDLE;
            sdram_ctrl_pkg::ST_CLOSE:
            begin
                // Longest of active time and write recovery governs the close
                if (ras_ok && wr_ok)
                begin
                    if (row_open)
                    begin
                        next_cmd = `CMD_PRE;
                        next_addr = 13'h0000;
                        next_ba = open_bank;
                    end
                    next_state = sdram_ctrl_pkg::ST_WAIT;
                    next_ret = sdram_ctrl_pkg::ST_IDLE;
                    load = 1'b1;
                    load_val = 15'(t.precharge_period) - 15'h0002;
                end
            end
            sdram_ctrl_pkg::ST_WAIT:
            begin
                if (timer_zero)
                    next_state = ret_state;
            end
            default: next_state = sdram_ctrl_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= sdram_ctrl_pkg::ST_OFF;
            ret_state <= sdram_ctrl_pkg::ST_IDLE;
            cmd <= `CMD_NOP;
            sdram_addr <= 13'h0000;
            sdram_ba <= 2'h0;
        end
        else
        begin
            state <= next_state;
            ret_state <= next_ret;
            cmd <= next_cmd;
            sdram_addr <= next_addr;
            sdram_ba <= next_ba;
        end
    end

    assign sdram_cs_n = cmd[3];
    assign sdram_ras_n = cmd[2];
    assign sdram_cas_n = cmd[1];
    assign sdram_we_n = cmd[0];

    // ****************************************
    // Initialization status
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (reset)
            ref_left <= `INIT_REFRESHES;
        else if (state == sdram_ctrl_pkg::ST_INIT_PRE)
            ref_left <= `INIT_REFRESHES;
        else if (state == sdram_ctrl_pkg::ST_INIT_REF)
            ref_left <= ref_left - 2'h1;
    end

    // Idle is reached only once initialization has finished
    always_ff @(posedge clk)
    begin
        if (reset)
            init_done <= 1'b0;
        else if (next_state == sdram_ctrl_pkg::ST_IDLE)
            init_done <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            mem_ready <= 1'b0;
        else
            mem_ready <= enable && init_done;
    end

    // ****************************************
    // Refresh timing
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (reset || !init_done)
            refresh_count <= REFRESH_CYCLES;
        else if (refresh_count == 10'h000)
            refresh_count <= REFRESH_CYCLES;
        else
            refresh_count <= refresh_count - 10'h001;
    end

    // A new tick wins over the clear
    always_ff @(posedge clk)
    begin
        if (reset)
            refresh_due <= 1'b0;
        else
            refresh_due <= (refresh_due && !(next_cmd == `CMD_REF && init_done)) ||
                           (init_done && refresh_count == 10'h000);
    end

    // ****************************************
    // Open row and bank timing
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            row_open <= 1'b0;
            open_row <= 13'h0000;
            open_bank <= 2'h0;
        end
        else if (next_cmd == `CMD_ACT)
        begin
            row_open <= 1'b1;
            open_row <= next_addr;
            open_bank <= next_ba;
        end
        else if (next_cmd == `CMD_PRE)
            row_open <= 1'b0;
        else if ((next_cmd == `CMD_READ || next_cmd == `CMD_WRITE) && auto_pre)
            row_open <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            ras_count <= 5'h1F;
        else if (next_cmd == `CMD_ACT)
            ras_count <= 5'h00;
        else if (ras_count != 5'h1F)
            ras_count <= ras_count + 5'h01;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            wr_count <= 5'h1F;
        else if (next_cmd == `CMD_WRITE)
            wr_count <= 5'h00;
        else if (wr_count != 5'h1F)
            wr_count <= wr_count + 5'h01;
    end

    // ****************************************
    // Data path
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            dq_meta <= 32'h00000000;
            dq_sync <= 32'h00000000;
        end
        else
        begin
            dq_meta <= sdram_dq_in;
            dq_sync <= dq_meta;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sdram_dq_out <= 32'h00000000;
            sdram_dq_oe <= 2'h0;
        end
        else if (next_cmd == `CMD_WRITE)
        begin
            sdram_dq_out <= req_wdata;
            sdram_dq_oe <= {t.bus32, 1'b1};
        end
        else
            sdram_dq_oe <= 2'h0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            req_ack <= 1'b0;
            req_rdata <= 32'h00000000;
        end
        else
        begin
            req_ack <= next_cmd == `CMD_WRITE || state == sdram_ctrl_pkg::ST_CAP;
            if (state == sdram_ctrl_pkg::ST_CAP)
                req_rdata <= t.bus32 ? dq_sync : {16'h0000, dq_sync[15:0]};
        end
    end

    // ****************************************
    // Clock enable
    // ****************************************
    // Dropping it in idle saves power but costs one wake cycle per request
    always_ff @(posedge clk)
    begin
        if (reset)
            sdram_clock_enable_out <= 1'b0;
        else if (!dyn_cke)
            sdram_clock_enable_out <= 1'b1;
        else if (state == sdram_ctrl_pkg::ST_OFF && next_state == sdram_ctrl_pkg::ST_OFF)
            sdram_clock_enable_out <= 1'b0;
        else if (state == sdram_ctrl_pkg::ST_IDLE && next_state == sdram_ctrl_pkg::ST_IDLE && !work)
            sdram_clock_enable_out <= 1'b0;
        else
            sdram_clock_enable_out <= 1'b1;
    end
endmodule : sdram_ctrl

// File: sim/sdram_ctrl_monitor.sv
// Pin and register-port checker of the SDRAM controller
// Assumes binding into sdram_ctrl; sees its ports only
`timescale 1ns/10ps
module sdram_ctrl_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic [12:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic req_ack,
    input wire logic mem_ready,
    input wire logic sdram_clock_enable_out,
    input wire logic sdram_cs_n,
    input wire logic sdram_ras_n,
    input wire logic sdram_cas_n,
    input wire logic sdram_we_n,
    input wire logic [12:0] sdram_addr,
    input wire logic [1:0] sdram_dq_oe
);
    // ****
    // Shadows and properties
    // ****
    logic [3:0] cmd;
    logic col;
    logic [15:0] en;
    logic [15:0] tc;
    logic [15:0] pw;
    assign cmd = {sdram_cs_n, sdram_ras_n, sdram_cas_n, sdram_we_n};
    assign col = cmd[3:1] == 3'h2;
    // Shadows let timing checks follow what software set
    always_ff @(posedge clk)
    begin
        en <= reset ? 16'h0002 : reg_wr && reg_addr == 13'h1C02 ? reg_wdata : en;
        tc <= reset ? 16'h7AAF : reg_wr && reg_addr == 13'h1C04 ? reg_wdata : tc;
        pw <= reset ? 16'hC010 : reg_wr && reg_addr == 13'h1C06 ? reg_wdata : pw;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_ack_ready: assert property (req_ack |-> mem_ready) else $error("ack not ready");
    a_off_quiet: assert property ((!en[0]) [*2] |-> cmd[3:1] != 3'h2 && cmd != 4'h3) else $error("access off");
    a_bus_width: assert property (cmd == 4'h4 |-> sdram_dq_oe == (en[2:1] == 2'h2 ? 2'h3 : 2'h1)) else $error("width");
    a_act_col: assert property (cmd == 4'h3 |-> ##2
        ((tc[3:2] == 2'h2 && col) or (tc[3:2] != 2'h2 && cmd == 4'h7 ##1 col))) else $error("ras to cas");
    a_read_lat: assert property (cmd == 4'h5 |-> ##5
        ((tc[1:0] == 2'h2 && req_ack) or (tc[1:0] != 2'h2 && !req_ack ##1 req_ack))) else $error("read latency");
    a_auto_pre: assert property (col |-> sdram_addr[10] == pw[3]) else $error("auto precharge");
    a_cke_fixed: assert property ((!pw[14]) [*2] |-> sdram_clock_enable_out) else $error("cke low");
    a_pre_gap: assert property (cmd == 4'h2 && tc[5:4] != 2'h1 |-> ##1 (cmd == 4'h7) [*2]) else $error("precharge gap");
    c_read: cover property (cmd == 4'h5);
    c_refresh: cover property (cmd == 4'h1);
    c_precharge: cover property (cmd == 4'h2);
endmodule : sdram_ctrl_monitor
bind sdram_ctrl sdram_ctrl_monitor mon (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .req_ack, .mem_ready,
    .sdram_clock_enable_out, .sdram_cs_n, .sdram_ras_n, .sdram_cas_n, .sdram_we_n, .sdram_addr, .sdram_dq_oe);

// File: sim/sdram_model.sv
// Behavioural SDRAM memory for the controller bench
// Assumes no board delay; latency taken from the mode command
`timescale 1ns/10ps
module sdram_model (
    input wire logic clk,
    input wire logic [3:0] cmd,
    input wire logic [1:0] sdram_ba,
    input wire logic [12:0] sdram_addr,
    input wire logic [31:0] sdram_dq_out,
    output logic [31:0] sdram_dq_in = 32'h5A5A5A5A
);
    logic [31:0] mem [logic [24:0]];
    logic [12:0] row [4];
    logic [2:0] lat = 3'h3;
    task automatic give(input logic [31:0] v);
        repeat (lat - 3'h1) @(posedge clk);
        sdram_dq_in <= v;
        @(posedge clk);
        sdram_dq_in <= ~v; // Released bus never keeps old data
    endtask : give
    always @(posedge clk)
    begin
        if (cmd == 4'h0)
            lat <= sdram_addr[6:4];
        if (cmd == 4'h3)
            row[sdram_ba] <= sdram_addr;
        if (cmd == 4'h4)
            mem[{sdram_ba, row[sdram_ba], sdram_addr[9:0]}] = sdram_dq_out;
        if (cmd == 4'h5)
            fork
                give(mem[{sdram_ba, row[sdram_ba], sdram_addr[9:0]}]);
            join_none
    end
endmodule : sdram_model

// File: sim/tb_sdram_config_and_timing_control.sv
// Self-checking bench: registers, gated start-up, random traffic
// Assumes the power-up wait is cut to 20 cycles
`timescale 1ns/10ps
module tb_sdram_config_and_timing_control;
    // ****
    // Stimulus and checks
    // ****
    logic clk = 1'h0, reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, req = 1'h0, req_we = 1'h0, w32;
    logic req_ack, mem_ready, sdram_clock_enable_out, sdram_cs_n, sdram_ras_n, sdram_cas_n, sdram_we_n;
    logic [12:0] reg_addr = 13'h0000, sdram_addr;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv, tcv, pwv;
    logic [23:0] req_addr = 24'h000000, a;
    logic [31:0] req_wdata = 32'h00000000, req_rdata, sdram_dq_out, sdram_dq_in, d;
    logic [1:0] sdram_ba, sdram_dq_oe;
    logic [31:0] shadow [logic [23:0]];
    int err_total = 0, total_checks = 0, n, seed = 32'hAA753085;
    initial forever #5 clk = ~clk;
    sdram_ctrl #(.INIT_WAIT_CYCLES(15'h0014)) DUT (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .req, .req_we, .req_addr, .req_wdata, .req_ack, .req_rdata, .mem_ready, .sdram_clock_enable_out, .sdram_cs_n,
        .sdram_ras_n, .sdram_cas_n, .sdram_we_n, .sdram_ba, .sdram_addr, .sdram_dq_out, .sdram_dq_oe, .sdram_dq_in);
    sdram_model MEM (.clk, .cmd({sdram_cs_n, sdram_ras_n, sdram_cas_n, sdram_we_n}), .sdram_ba, .sdram_addr,
        .sdram_dq_out, .sdram_dq_in);
    function automatic logic [31:0] seen(input logic [31:0] v);
        return w32 ? v : {16'h0000, v[15:0]};
    endfunction : seen
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [12:0] ad, input logic [15:0] v);
        reg_addr <= ad;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [12:0] ad);
        reg_addr <= ad;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 rv = reg_rdata;
        @(posedge clk);
    endtask : rd
    task automatic acc(input logic we, input logic [23:0] ad, input logic [31:0] v);
        req <= 1'h1;
        req_we <= we;
        req_addr <= ad;
        req_wdata <= v;
        for (n = 0; n < 3000 && req_ack !== 1'h1; n++)
            @(posedge clk);
        if (n == 3000)
        begin
            err_total++;
            $display("[ERR] %0t no ack", $time);
            wrap_up();
        end
        req <= 1'h0;
        @(posedge clk);
    endtask : acc
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        rd(13'h1C02);
        chk(32'(rv), 32'h00000002);
        rd(13'h1C04);
        chk(32'(rv), 32'h00007AAF);
        rd(13'h1C06);
        chk(32'(rv), 32'h0000C010);
        wr(13'h1C02, 16'h0082);
        rd(13'h1C02);
        chk(32'(rv), 32'h00000002);
        wr(13'h1C00, 16'h0011);
        rd(13'h1C00);
        chk(32'(rv), 32'h00000000);
        $display("Register test done");
        d = $random(seed);
        w32 = d[4];
        tcv = 16'($random(seed)) | 16'h025A;
        if (tcv[7:6] == 2'h1)
            tcv[3:2] = 2'h3;
        pwv = {1'h1, d[0], 9'h000, 1'h1, d[1], d[3:2], 1'h0};
        wr(13'h1C04, tcv);
        wr(13'h1C06, pwv);
        rd(13'h1C04);
        chk(32'(rv), 32'(tcv));
        req <= 1'h1;
        req_we <= 1'h1;
        req_addr <= 24'h000010;
        req_wdata <= d;
        n = 0;
        repeat (30)
        begin
            @(posedge clk);
            n += req_ack;
        end
        chk(32'(n), 32'h00000000);
        req <= 1'h0;
        wr(13'h1C02, {13'h0000, w32, ~w32, 1'h1});
        rv = 16'h0000;
        for (n = 0; n < 200 && rv[7] !== 1'h1; n++)
            rd(13'h1C02);
        chk(32'(rv), 32'({8'h00, 1'h1, 4'h0, w32, ~w32, 1'h1}));
        acc(1'h1, 24'h000010, d);
        shadow[24'h000010] = d;
        $display("Start-up test done");
        for (int i = 0; i < 60; i++)
        begin
            a = 24'($random(seed)) & 24'h0C0C07;
            d = $random(seed);
            if (i == 30)
                wr(13'h1C06, pwv ^ 16'h4000);
            if (shadow.exists(a) && d[0])
            begin
                acc(1'h0, a, d);
                chk(req_rdata, seen(shadow[a]));
            end
            else
            begin
                acc(1'h1, a, d);
                shadow[a] = d;
            end
        end
        wr(13'h1C02, 16'h0000);
        rd(13'h1C02);
        chk(32'(mem_ready), 32'h00000000);
        $display("Traffic test done");
        wrap_up();
    end
endmodule : tb_sdram_config_and_timing_control
